/* bench/dps_ctrl_model.sv */
// Controller-side model: drives CKE and the command pins of the power-state block.
// Assumes the bench asks for levels and commands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dps_ctrl_model (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic want_cke_in,
   input wire dps_pkg::dps_cmd_t want_cmd_in,
   input wire logic a10_in,
   output logic cke_out,
   output dps_pkg::dps_pins_t pins_out
);
   import dps_pkg::*;
   logic [1:0] held; // Edges on which the present CKE level was registered.
   logic [2:0] code; // RAS#, CAS#, WE# of the requested command.
   // -----------------------------------------------------------------
   // Command encoding; the chip select is always low.
   // -----------------------------------------------------------------
   always_comb begin
      case (want_cmd_in)
         DPS_CMD_ACT: code = 3'h3;
         DPS_CMD_RD: code = 3'h5;
         DPS_CMD_WR: code = 3'h4;
         DPS_CMD_PRE: code = 3'h2;
         DPS_CMD_REF: code = 3'h1;
         DPS_CMD_LM: code = 3'h0;
         DPS_CMD_OTHER: code = 3'h6;
         default: code = 3'h7;
      endcase
   end
   // A level change waits for three registrations, so a hasty bench
   // request is delayed rather than breaking the hold time; NOP meanwhile.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cke_out <= 1'b1;
         held <= 2'h3;
         // No termination pin reaches the block; it stays off throughout.
         pins_out <= {1'b0, 3'h7, 1'b0, 2'h0};
      end else if (want_cke_in != cke_out && held != 2'h3) begin
         held <= held + 2'h1;
         pins_out <= {1'b0, 3'h7, 1'b0, 2'h0};
      end else begin
         cke_out <= want_cke_in;
         held <= (want_cke_in != cke_out) ? 2'h1 : ((held == 2'h3) ? held : held + 2'h1);
         pins_out <= {1'b0, code, a10_in, 2'h0};
      end
   end
endmodule : dps_ctrl_model
`default_nettype wire

/* bench/testbench.sv */
// Bench for the power-state block: a table of transitions, then refusals.
// Assumes the controller model drives the pins; core busy flags come from here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dps_pkg::*;
   typedef struct packed {
      logic cke;
      dps_cmd_t cmd;
      logic a10;
      dps_state_t st;
   } dps_row_t;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic want_cke = 1'b1;
   dps_cmd_t want_cmd = DPS_CMD_NOP;
   logic a10 = 1'b0;
   logic [2:0] busy = 3'h0; // Burst, mode and precharge busy.
   logic cke;
   dps_pins_t pins;
   dps_state_t state_out;
   dps_status_t status_out;
   logic read_allowed_out;
   logic refresh_run_out;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   dps_row_t rows [12];
   dps_cmd_t bad [6] = '{DPS_CMD_RD, DPS_CMD_NOP, DPS_CMD_NOP, DPS_CMD_NOP, DPS_CMD_REF,
      DPS_CMD_ACT};

   // 125 MHz clock.
   initial begin
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   dps_ctrl_model ctrl (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .want_cke_in(want_cke), .want_cmd_in(want_cmd), .a10_in(a10), .cke_out(cke),
      .pins_out(pins));
   dps_power_state dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cke_in(cke),
      .pins_in(pins), .burst_busy_in(busy[2]), .mode_busy_in(busy[1]),
      .precharge_busy_in(busy[0]), .state_out(state_out), .status_out(status_out),
      .read_allowed_out(read_allowed_out), .refresh_run_out(refresh_run_out));

   // -----------------------------------------------------------------
   // Shared tasks.
   // -----------------------------------------------------------------
   task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Outputs settle three edges after the pins, so six edges is ample.
   task automatic drive(input logic c, input dps_cmd_t m, input logic a);
      @(posedge sys_clk_in);
      #1;
      want_cke = c;
      want_cmd = m;
      a10 = a;
      @(posedge sys_clk_in);
      #1;
      want_cmd = DPS_CMD_NOP;
      repeat (6) @(posedge sys_clk_in);
      #1;
   endtask : drive

   task automatic see(input dps_state_t st);
      chk("state", st, state_out);
      chk("illegal", 5'(st == DPS_ST_ILLEGAL), 5'(status_out.illegal));
      if (st != DPS_ST_ILLEGAL) begin
         chk("in_sref", 5'(st == DPS_ST_SREF), 5'(status_out.in_sref));
         chk("refresh_run", 5'(st == DPS_ST_SREF), 5'(refresh_run_out));
      end
      // Self refresh leaves buffer and loop flags to the design's own choice.
      if (st inside {DPS_ST_ACTIVE, DPS_ST_PPD, DPS_ST_APD}) begin
         chk("in_pd", 5'(st != DPS_ST_ACTIVE), 5'(status_out.in_pd));
         chk("bufs_off", 5'(st != DPS_ST_ACTIVE), 5'(status_out.bufs_off));
         chk("dll_frozen", 5'(st == DPS_ST_PPD), 5'(status_out.dll_frozen));
      end
   endtask : see

   task automatic do_reset();
      reset_n_in = 1'b0;
      busy = 3'h0;
      want_cke = 1'b1;
      want_cmd = DPS_CMD_NOP;
      repeat (8) @(posedge sys_clk_in);
      #1;
      chk("reset state", DPS_ST_ACTIVE, state_out);
      chk("reset status", 5'h00, status_out);
      chk("reset read", 5'h00, 5'(read_allowed_out));
      reset_n_in = 1'b1;
      repeat (2) @(posedge sys_clk_in);
      #1;
   endtask : do_reset

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   // Hang guard; the whole run needs well under a thousand cycles.
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   // -----------------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------------
   initial begin
      rows[0] = '{1'b1, DPS_CMD_NOP, 1'b0, DPS_ST_ACTIVE};
      rows[1] = '{1'b0, DPS_CMD_NOP, 1'b0, DPS_ST_PPD};
      rows[2] = '{1'b1, DPS_CMD_NOP, 1'b0, DPS_ST_ACTIVE};
      rows[3] = '{1'b1, DPS_CMD_ACT, 1'b0, DPS_ST_ACTIVE};
      rows[4] = '{1'b0, DPS_CMD_NOP, 1'b0, DPS_ST_APD};
      rows[5] = '{1'b1, DPS_CMD_NOP, 1'b0, DPS_ST_ACTIVE};
      rows[6] = '{1'b1, DPS_CMD_PRE, 1'b1, DPS_ST_ACTIVE};
      rows[7] = '{1'b0, DPS_CMD_NOP, 1'b0, DPS_ST_PPD};
      rows[8] = '{1'b1, DPS_CMD_NOP, 1'b0, DPS_ST_ACTIVE};
      rows[9] = '{1'b1, DPS_CMD_LM, 1'b0, DPS_ST_ACTIVE};
      rows[10] = '{1'b0, DPS_CMD_REF, 1'b0, DPS_ST_SREF};
      rows[11] = '{1'b1, DPS_CMD_NOP, 1'b0, DPS_ST_ACTIVE};
      do_reset();
      foreach (rows[i]) begin
         drive(rows[i].cke, rows[i].cmd, rows[i].a10);
         see(rows[i].st);
      end
      // Reads stay barred for the exit interval, counted from the edge that
      // decides the exit; drive returns three edges after that edge.
      repeat (DPS_XSRD_CYC - 4) @(posedge sys_clk_in);
      #1;
      chk("read early", 5'h00, 5'(read_allowed_out));
      @(posedge sys_clk_in);
      #1;
      chk("read late", 5'h01, 5'(read_allowed_out));
      @(posedge sys_clk_in);
      #1;
      chk("read stays", 5'h01, 5'(read_allowed_out));
      // Active power-down one cycle after ACTIVATE.
      do_reset();
      want_cmd = DPS_CMD_ACT;
      @(posedge sys_clk_in);
      #1;
      want_cmd = DPS_CMD_NOP;
      want_cke = 1'b0;
      repeat (6) @(posedge sys_clk_in);
      #1;
      see(DPS_ST_APD);
      // A write with auto precharge closes its bank, so entry is precharge power-down.
      do_reset();
      drive(1'b1, DPS_CMD_ACT, 1'b0);
      drive(1'b1, DPS_CMD_WR, 1'b1);
      drive(1'b0, DPS_CMD_NOP, 1'b0);
      see(DPS_ST_PPD);
      // Refused entries and exits each end in the illegal state.
      for (int i = 0; i < 6; i++) begin
         do_reset();
         if (i == 4) drive(1'b1, DPS_CMD_ACT, 1'b0);
         if (i == 5) drive(1'b0, DPS_CMD_NOP, 1'b0);
         busy = (i inside {[1:3]}) ? 3'(4 >> (i - 1)) : 3'h0;
         drive(i == 5, bad[i], 1'b0);
         see(DPS_ST_ILLEGAL);
      end
      wrap_up();
   end
endmodule : testbench
`default_nettype wire

/* rtl/dps_pkg.sv */
// Package for the clock-enable power-state block of a four-bank DDR2 device.
// Assumes a single 125 MHz clock domain; the memory clock pair is sys_clk_in.
package dps_pkg;

   // -----------------------------------------------------------------
   // Commands decoded from the select/row/column/write-enable pins.
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      DPS_CMD_NOP = 3'h0,
      DPS_CMD_ACT = 3'h1,
      DPS_CMD_RD = 3'h2,
      DPS_CMD_WR = 3'h3,
      DPS_CMD_PRE = 3'h4,
      DPS_CMD_REF = 3'h5,
      DPS_CMD_LM = 3'h6,
      DPS_CMD_OTHER = 3'h7
   } dps_cmd_t;

   // Power states, one-hot.
   typedef enum logic [4:0] {
      DPS_ST_ACTIVE = 5'h01,
      DPS_ST_PPD = 5'h02,
      DPS_ST_APD = 5'h04,
      DPS_ST_SREF = 5'h08,
      DPS_ST_ILLEGAL = 5'h10
   } dps_state_t;

   // Command pin group sampled together with the clock enable.
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic a10;
      logic [1:0] bank;
   } dps_pins_t;

   // Status bundle shown to the core.
   typedef struct packed {
      logic in_pd;
      logic in_sref;
      logic dll_frozen;
      logic bufs_off;
      logic illegal;
   } dps_status_t;

   // -----------------------------------------------------------------
   // Timing counts in memory clock cycles.
   // -----------------------------------------------------------------
   localparam int unsigned DPS_XSRD_CYC = 200;
   localparam logic [7:0] DPS_XSRD_CNT = 8'(DPS_XSRD_CYC);
   localparam logic [7:0] DPS_CNT_RST = 8'h00;
   localparam logic [3:0] DPS_BANKS_RST = 4'h0;
   localparam logic [1:0] DPS_CKE_HOLD_CNT = 2'h3;
   // Idle pin levels for the synchroniser reset: CKE high, chip deselected.
   // A reset value of zero would read as a CKE fall with a mode load.
   localparam logic [7:0] DPS_SYNC_RST = 8'hFF;
   localparam logic DPS_CKE_RST = 1'b1;

endpackage : dps_pkg

/* rtl/dps_power_state.sv */
// Clock-enable driven power-state logic of a four-bank DDR2 device.
// Assumes CKE and the command pins arrive from the controller's pins and
// are synchronised here; burst/mode busy flags come from the core logic.
// Functional notes
// - Self refresh: CKE fall, REFRESH, banks idle
// - Burst complete after postamble and recovery
// - Power-down entry: CKE low with NOP
// - Idle banks precharge, open rows active
// - Buffers off, DLL frozen in precharge
// - No refresh performed during power-down
// - Exit on first CKE high with NOP
`timescale 1ns/1ps
`default_nettype none
module dps_power_state (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic cke_in,
   input wire dps_pkg::dps_pins_t pins_in,
   input wire logic burst_busy_in,
   input wire logic mode_busy_in,
   input wire logic precharge_busy_in,
   output dps_pkg::dps_state_t state_out,
   output dps_pkg::dps_status_t status_out,
   output logic read_allowed_out,
   output logic refresh_run_out
);
   import dps_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   // Clock enable and command pins travel as one word through two flops.
   dps_pins_t pins_s;
   logic cke_s;
   // Reset to CKE high and deselect, so the first edges after reset look idle.
   dps_sync2 #(.W(8), .RST_VAL(DPS_SYNC_RST)) u_sync (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .d_in({cke_in, pins_in}),
      .q_out({cke_s, pins_s})
   );

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   dps_cmd_t cmd; // Command registered at this edge.
   always_comb begin
      if (pins_s.cs_n) begin
         cmd = DPS_CMD_NOP; // Deselect counts as NOP.
      end else begin
         case ({pins_s.ras_n, pins_s.cas_n, pins_s.we_n})
            3'h7: cmd = DPS_CMD_NOP;
            3'h3: cmd = DPS_CMD_ACT;
            3'h5: cmd = DPS_CMD_RD;
            3'h4: cmd = DPS_CMD_WR;
            3'h2: cmd = DPS_CMD_PRE;
            3'h1: cmd = DPS_CMD_REF;
            3'h0: cmd = DPS_CMD_LM;
            default: cmd = DPS_CMD_OTHER;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registered state
   // ---------------------------------------------------------------
   dps_state_t state; // Current power state.
   dps_state_t next_state;
   logic cke_prev; // CKE at the previous edge.
   logic next_cke_prev;
   logic [3:0] open_rows; // One bit per bank with an open row.
   logic [3:0] next_open_rows;
   logic [7:0] xsrd_cnt; // Cycles left before a READ may follow sref exit.
   logic [7:0] next_xsrd_cnt;
   logic busy; // Any operation that forbids entry.

   // Busy covers bursts through postamble and recovery, mode loads and
   // precharges; the core asserts these for their full duration.
   assign busy = burst_busy_in | mode_busy_in | precharge_busy_in;

   // Bank tracking; a row opens on ACTIVATE and closes on PRECHARGE.
   always_comb begin
      next_open_rows = open_rows;
      if (state == DPS_ST_ACTIVE && cke_s) begin
         if (cmd == DPS_CMD_ACT) begin
            next_open_rows[pins_s.bank] = 1'b1;
         end else if (cmd == DPS_CMD_PRE) begin
            if (pins_s.a10) begin
               next_open_rows = DPS_BANKS_RST;
            end else begin
               next_open_rows[pins_s.bank] = 1'b0;
            end
         end else if ((cmd == DPS_CMD_RD || cmd == DPS_CMD_WR) && pins_s.a10) begin
            // Auto precharge closes the bank; the burst flag covers the
            // burst and recovery until entry becomes legal.
            next_open_rows[pins_s.bank] = 1'b0;
         end
      end
   end

   // Power-state transitions, evaluated on each rising edge.
   always_comb begin
      next_state = state;
      next_cke_prev = cke_s;
      next_xsrd_cnt = (xsrd_cnt != DPS_CNT_RST) ? xsrd_cnt - 8'h01 : xsrd_cnt;
      case (state)
         DPS_ST_ACTIVE: begin
            if (cke_prev && !cke_s) begin
               if (cmd == DPS_CMD_REF && open_rows == DPS_BANKS_RST && !busy) begin
                  next_state = DPS_ST_SREF;
               end else if (cmd == DPS_CMD_NOP && !busy) begin
                  // Entry one cycle after REF/ACT/PRE is fine; only
                  // the busy flags hold it off.
                  if (open_rows == DPS_BANKS_RST) begin
                     next_state = DPS_ST_PPD;
                  end else begin
                     next_state = DPS_ST_APD;
                  end
               end else begin
                  next_state = DPS_ST_ILLEGAL;
               end
            end else if (!cke_prev && !cke_s) begin
               next_state = DPS_ST_ILLEGAL;
            end
         end
         DPS_ST_PPD, DPS_ST_APD: begin
            if (cke_s) begin
               if (cmd == DPS_CMD_NOP) begin
                  next_state = DPS_ST_ACTIVE;
               end else begin
                  next_state = DPS_ST_ILLEGAL;
               end
            end
         end
         DPS_ST_SREF: begin
            if (cke_s) begin
               if (cmd == DPS_CMD_NOP) begin
                  next_state = DPS_ST_ACTIVE;
                  next_xsrd_cnt = DPS_XSRD_CNT;
               end else begin
                  next_state = DPS_ST_ILLEGAL;
               end
            end
         end
         DPS_ST_ILLEGAL: begin
            // Stays here until reset; behaviour is not guaranteed.
            next_state = DPS_ST_ILLEGAL;
         end
         default: next_state = DPS_ST_ILLEGAL;
      endcase
   end

   // Register the state group.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= DPS_ST_ACTIVE;
         cke_prev <= DPS_CKE_RST;
         open_rows <= DPS_BANKS_RST;
         xsrd_cnt <= DPS_CNT_RST;
      end else begin
         state <= next_state;
         cke_prev <= next_cke_prev;
         open_rows <= next_open_rows;
         xsrd_cnt <= next_xsrd_cnt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all registered
   // ---------------------------------------------------------------
   dps_status_t next_status;
   logic next_read_allowed;
   logic next_refresh_run;

   // Buffers are off in every low-power state; the DLL freezes only in
   // precharge power-down. No refresh runs in power-down.
   always_comb begin
      next_status.in_pd = (next_state == DPS_ST_PPD) || (next_state == DPS_ST_APD);
      next_status.in_sref = (next_state == DPS_ST_SREF);
      next_status.dll_frozen = (next_state == DPS_ST_PPD);
      next_status.bufs_off = next_status.in_pd || next_status.in_sref;
      next_status.illegal = (next_state == DPS_ST_ILLEGAL);
      next_refresh_run = (next_state == DPS_ST_SREF);
      next_read_allowed = (next_state == DPS_ST_ACTIVE) && (next_xsrd_cnt == DPS_CNT_RST);
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_out <= DPS_ST_ACTIVE;
         status_out <= '0;
         read_allowed_out <= 1'b0;
         refresh_run_out <= 1'b0;
      end else begin
         state_out <= next_state;
         status_out <= next_status;
         read_allowed_out <= next_read_allowed;
         refresh_run_out <= next_refresh_run;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_sref_entry;
      state == DPS_ST_ACTIVE && cke_prev && !cke_s && cmd == DPS_CMD_REF
         && open_rows == 4'h0 && !busy;
   endsequence

   a_sref_entry: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      s_sref_entry |=> state == DPS_ST_SREF ##1 status_out.in_sref && refresh_run_out)
      else $error("Self refresh not entered.");

   a_pd_kind: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (state == DPS_ST_ACTIVE && cke_prev && !cke_s && cmd == DPS_CMD_NOP && !busy)
      |=> (state == DPS_ST_PPD) == ($past(open_rows) == 4'h0))
      else $error("Wrong power-down kind.");

   a_pd_exit: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      ((state == DPS_ST_PPD || state == DPS_ST_APD) && cke_s && cmd == DPS_CMD_NOP)
      |=> state == DPS_ST_ACTIVE)
      else $error("Power-down exit missed.");

   a_busy_entry: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (state == DPS_ST_ACTIVE && cke_prev && !cke_s && busy) |=> state == DPS_ST_ILLEGAL)
      else $error("Entry while busy not flagged.");

   a_dll_freeze: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      state == DPS_ST_PPD |=> status_out.dll_frozen || state != DPS_ST_PPD)
      else $error("DLL not frozen in precharge power-down.");

   a_no_pd_refresh: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      status_out.in_pd |-> !refresh_run_out)
      else $error("Refresh during power-down.");

   a_read_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (state == DPS_ST_SREF && cke_s && cmd == DPS_CMD_NOP) |=> !read_allowed_out [*8])
      else $error("Read allowed too early.");

   // Cycles since the last self refresh exit, for the read-exit checks.
   // It saturates so a long active period cannot wrap it back into range.
   logic [7:0] chk_cnt;
   logic [7:0] next_chk_cnt;
   always_comb begin
      next_chk_cnt = chk_cnt;
      if (state == DPS_ST_SREF && cke_s && cmd == DPS_CMD_NOP) begin
         next_chk_cnt = 8'h01;
      end else if (state != DPS_ST_ACTIVE) begin
         next_chk_cnt = DPS_CNT_RST;
      end else if (chk_cnt != DPS_CNT_RST && chk_cnt != 8'hFF) begin
         next_chk_cnt = chk_cnt + 8'h01;
      end
   end
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         chk_cnt <= DPS_CNT_RST;
      end else begin
         chk_cnt <= next_chk_cnt;
      end
   end

   a_read_open: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (chk_cnt == (DPS_XSRD_CNT + 8'h01)) |-> read_allowed_out)
      else $error("Read not allowed after exit interval.");

   a_read_barred: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (chk_cnt != DPS_CNT_RST && chk_cnt <= DPS_XSRD_CNT) |-> !read_allowed_out)
      else $error("Read allowed inside exit interval.");

   a_bad_cmd: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      ((state == DPS_ST_PPD || state == DPS_ST_APD) && cke_s && cmd != DPS_CMD_NOP)
      |=> ##1 status_out.illegal)
      else $error("Bad exit command not flagged.");

endmodule : dps_power_state
`default_nettype wire

/* rtl/dps_sync2.sv */
// Two-stage synchroniser for pin inputs.
// Assumes the pin is asynchronous to sys_clk_in; only stage two is read.
`timescale 1ns/1ps
`default_nettype none
module dps_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   // First stage feeds the second only, to let metastability settle.
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // Next values are the plain shift.
   always_comb begin
      next_meta = d_in;
      next_q = meta;
   end

   // Register both stages.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         // Both stages start at the pin's idle level, so no false edge follows reset.
         meta <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta <= next_meta;
         q_out <= next_q;
      end
   end
endmodule : dps_sync2
`default_nettype wire
